// ---- src/ccms_pkg.sv ----
// Contract
// RULE1 - bit 3 of the register set means legacy call mode, clear means extended
// RULE2 - a call pushes 2 stack bytes in legacy mode, 3 in extended mode
// RULE3 - wide branch and wide call execute only in extended call mode
// RULE4 - absolute call 3 or 4 cycles, fast call 2 or 3 cycles
// RULE5 - reset sets bit 3, so the CPU starts in legacy call mode
// RULE6 - register at data address F84H, written by 4-bit memory operations
// RULE7 - stack area selects bank 0 or bank 1; other codes are forbidden
// RULE8 - software always writes 0 to bit 2
// RULE9 - software initialises upper bits to 100 or 000 at program start
// RULE10 - one CPU clock period counts as one machine cycle
// RULE11 - stack field is bits 1:0, 00 bank 0, 01 bank 1, drives pointer bank
// RULE12 - a mode change affects only instructions started after the write
package ccms_pkg;

  // ==========================================================================
  // register map and fields
  localparam logic [11:0] CCMS_STACK_SEL_ADDR  = 12'hf84;
  localparam int          CCMS_MODE_BIT   = 3;
  localparam int          CCMS_RSVD_BIT   = 2;
  localparam logic [3:0]  CCMS_STACK_SEL_RESET = 4'h8;
  localparam logic [1:0]  CCMS_BANK0      = 2'h0;
  localparam logic [1:0]  CCMS_BANK1      = 2'h1;

  // ==========================================================================
  // per-mode figures
  localparam logic [1:0]  CCMS_PUSH_LEGACY  = 2'h2;
  localparam logic [1:0]  CCMS_PUSH_EXT     = 2'h3;
  localparam logic [2:0]  CCMS_CALL_LEGACY  = 3'h3;
  localparam logic [2:0]  CCMS_CALL_EXT     = 3'h4;
  localparam logic [2:0]  CCMS_FCALL_LEGACY = 3'h2;
  localparam logic [2:0]  CCMS_FCALL_EXT    = 3'h3;

  // instruction classes the sequencer reports at decode
  typedef enum logic [1:0] {
    CCMS_OP_OTHER = 2'b00,
    CCMS_OP_CALL  = 2'b01,
    CCMS_OP_FCALL = 2'b10,
    CCMS_OP_WIDE  = 2'b11
  } ccms_op_e;

  // data memory write strobe group
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  data;
  } ccms_wr_s;

  // mode view handed to the instruction sequencer
  typedef struct packed {
    logic       legacy;
    logic [1:0] push_bytes;
    logic       stack_bank;
  } ccms_mode_s;

endpackage

// ---- src/ccms_cycle_cnt.sv ----
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// machine cycle counter: one clock per machine cycle
module ccms_cycle_cnt
  import ccms_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       load,
  input  wire logic [2:0] len,
  output logic            busy,
  output logic            last
);

  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;

  // count down once per clock, load on instruction start
  assign cnt_nxt = load ? len : (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;  // [RULE10]
  assign busy    = cnt_r != 3'h0;
  assign last    = cnt_r == 3'h1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 3'h0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- src/ccms_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// call mode and stack bank select
module ccms_top
  import ccms_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire ccms_wr_s   mem_wr,
  input  wire logic [11:0] mem_rd_addr,
  output logic [3:0]      mem_rd_data,
  output logic            mem_rd_hit,
  input  wire logic       instr_start,
  input  wire ccms_op_e   instr_op,
  output logic            instr_illegal,
  output logic            instr_busy,
  output logic            instr_last,
  output logic [2:0]      instr_cycles,
  output ccms_mode_s      mode,
  output logic            bank_fault
);

  // ==========================================================================
  // register
  logic [3:0] bank_sel_r;
  logic [3:0] bank_sel_nxt;
  logic       sel_wr;
  logic       legacy_run_r;
  logic       legacy_now;

  // 4-bit memory write at the fixed data address
  assign sel_wr       = mem_wr.wr && (mem_wr.addr == CCMS_STACK_SEL_ADDR);  // [RULE6]
  assign bank_sel_nxt = sel_wr ? mem_wr.data : bank_sel_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_sel_r <= CCMS_STACK_SEL_RESET;                                  // [RULE5]
    end else if (ce) begin
      bank_sel_r <= bank_sel_nxt;
    end
  end

  // readback, registered data
  assign mem_rd_hit = mem_rd_addr == CCMS_STACK_SEL_ADDR;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_rd_data <= 4'h0;
    end else if (ce) begin
      mem_rd_data <= mem_rd_hit ? bank_sel_r : 4'h0;
    end
  end

  // ==========================================================================
  // mode latched per instruction so a write mid-instruction has no effect
  assign legacy_now = bank_sel_r[CCMS_MODE_BIT];                           // [RULE1]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      legacy_run_r <= 1'b1;
    end else if (ce && instr_start) begin
      legacy_run_r <= legacy_now;                                          // [RULE12]
    end
  end

  // ==========================================================================
  // derived mode view
  logic [1:0] push_w;
  assign push_w          = legacy_run_r ? CCMS_PUSH_LEGACY : CCMS_PUSH_EXT; // [RULE2]
  assign mode.legacy     = legacy_run_r;
  assign mode.push_bytes = push_w;
  assign mode.stack_bank = bank_sel_r[0];                                  // [RULE11]
  // encodings other than bank 0/1 flagged, bit 2 must stay clear
  assign bank_fault = (bank_sel_r[1:0] != CCMS_BANK0 && bank_sel_r[1:0] != CCMS_BANK1)
                      || bank_sel_r[CCMS_RSVD_BIT];                        // [RULE7]

  // ==========================================================================
  // instruction length and legality
  logic [2:0] len_w;
  logic       ill_w;
  assign len_w = (instr_op == CCMS_OP_CALL)  ? (legacy_now ? CCMS_CALL_LEGACY
                                                           : CCMS_CALL_EXT)   // [RULE4]
               : (instr_op == CCMS_OP_FCALL) ? (legacy_now ? CCMS_FCALL_LEGACY
                                                           : CCMS_FCALL_EXT)  // [RULE4]
               : 3'h1;
  assign ill_w = (instr_op == CCMS_OP_WIDE) && legacy_now;                 // [RULE3]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_cycles  <= 3'h0;
      instr_illegal <= 1'b0;
    end else if (ce && instr_start) begin
      instr_cycles  <= len_w;
      instr_illegal <= ill_w;
    end
  end

  ccms_cycle_cnt u_cnt (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .load (instr_start),
    .len  (len_w),
    .busy (instr_busy),
    .last (instr_last)
  );

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // register comes out of reset in legacy call mode
  reset_mode_a : assert property ($fell(rst) |-> bank_sel_r == CCMS_STACK_SEL_RESET) // [RULE5]
    else $error("register not at reset value");
  // a decoded write lands on the next edge
  write_take_a : assert property (ce && sel_wr |=> bank_sel_r == $past(mem_wr.data)) // [RULE6]
    else $error("register write lost");
  // writes to any other address leave the register alone
  other_addr_a : assert property (!sel_wr |=> $stable(bank_sel_r)) // [RULE6]
    else $error("register changed without a write");
  // clock enable low freezes the register
  ce_freeze_a : assert property (!ce |=> $stable(bank_sel_r)) // [RULE6]
    else $error("register changed while frozen");
  // readback shows the register one cycle after the address hits
  rd_data_a : assert property (ce |=> mem_rd_data
                               == ($past(mem_rd_hit) ? $past(bank_sel_r) : 4'h0)) // [RULE6]
    else $error("readback data wrong");
  // mode latched from the register at each instruction start
  mode_load_a : assert property (ce && instr_start
                                 |=> mode.legacy == $past(bank_sel_r[CCMS_MODE_BIT])) // [RULE12]
    else $error("mode not taken at start");
  push_cnt_a : assert property (mode.push_bytes == (mode.legacy ? 2'h2 : 2'h3)) // [RULE2]
    else $error("push byte count wrong");
  wide_ill_a : assert property (ce && instr_start && instr_op == CCMS_OP_WIDE
                                |=> instr_illegal == $past(bank_sel_r[3]))   // [RULE3]
    else $error("wide op legality wrong");
  // only wide ops can ever be flagged
  narrow_ok_a : assert property (ce && instr_start && instr_op != CCMS_OP_WIDE
                                 |=> !instr_illegal) // [RULE3]
    else $error("ordinary op flagged illegal");
  // flag stands until the next start
  ill_hold_a : assert property (!instr_start |=> $stable(instr_illegal)) // [RULE3]
    else $error("illegal flag moved");
  call_len_a : assert property (ce && instr_start && instr_op == CCMS_OP_CALL
                                |=> instr_cycles == ($past(bank_sel_r[3]) ? 3'h3 : 3'h4)) // [RULE4]
    else $error("call length wrong");
  fcall_len_a : assert property (ce && instr_start && instr_op == CCMS_OP_FCALL
                                 |=> instr_cycles == ($past(bank_sel_r[3]) ? 3'h2 : 3'h3)) // [RULE4]
    else $error("fast call length wrong");
  // non-call instructions take one machine cycle
  other_len_a : assert property (ce && instr_start && instr_op == CCMS_OP_OTHER
                                 |=> instr_cycles == 3'h1) // [RULE4]
    else $error("plain op length wrong");
  // reported length stands until the next start
  len_hold_a : assert property (!instr_start |=> $stable(instr_cycles)) // [RULE4]
    else $error("length moved mid instruction");
  mode_hold_a : assert property (!instr_start |=> $stable(mode.legacy)) // [RULE12]
    else $error("mode changed mid instruction");
  bank_sel_a : assert property (mode.stack_bank == bank_sel_r[0]) // [RULE11]
    else $error("stack bank wrong");
  // bank 0 code keeps the pointer in bank 0
  bank_zero_a : assert property (bank_sel_r[1:0] == CCMS_BANK0 |-> !mode.stack_bank) // [RULE11]
    else $error("bank 0 not selected");
  // any forbidden code raises the fault flag
  fault_flag_a : assert property (bank_sel_r[1] || bank_sel_r[CCMS_RSVD_BIT] |-> bank_fault) // [RULE7]
    else $error("forbidden code not flagged");
  busy_run_a : assert property (ce && instr_start && instr_op == CCMS_OP_CALL
                                && bank_sel_r[3] ##1 ce[*2] |-> instr_busy) // [RULE10]
    else $error("call ended early");
  // a start always leaves the counter busy
  start_busy_a : assert property (ce && instr_start |=> instr_busy) // [RULE10]
    else $error("counter not loaded");
  // last cycle is part of the busy window
  last_busy_a : assert property (instr_last |-> instr_busy) // [RULE10]
    else $error("last outside busy");
  // counter runs out one cycle after the last flag
  last_end_a : assert property (ce && instr_last && !instr_start |=> !instr_busy) // [RULE10]
    else $error("counter ran past last cycle");

  ext_call_c : cover property (ce && instr_start && instr_op == CCMS_OP_CALL && !bank_sel_r[3]);
  leg_wide_c : cover property (ce && instr_start && instr_op == CCMS_OP_WIDE && bank_sel_r[3]);
  mode_sw_c  : cover property (ce && sel_wr && !mem_wr.data[3]);
  leg_fcall_c : cover property (ce && instr_start && instr_op == CCMS_OP_FCALL && bank_sel_r[3]);
  bank1_c    : cover property (ce && sel_wr && mem_wr.data[1:0] == CCMS_BANK1);

endmodule
`default_nettype wire

// ---- verif/test_ccms_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// bench for call mode and stack bank select
module test_ccms_top
  import ccms_pkg::*;
;
  logic        clk = 0;
  logic        rst = 1;
  logic        ce = 1;
  logic        instr_start = 0;
  ccms_wr_s    mem_wr = '0;
  logic [11:0] mem_rd_addr = CCMS_STACK_SEL_ADDR;
  ccms_op_e    instr_op = CCMS_OP_OTHER;
  logic [3:0]  mem_rd_data;
  logic        mem_rd_hit, instr_illegal, instr_busy, instr_last, bank_fault;
  logic [2:0]  instr_cycles;
  ccms_mode_s  mode;
  int          num_errors = 0;
  int          num_checks = 0;
  localparam logic [11:0] A = CCMS_STACK_SEL_ADDR;
  ccms_top ccms_top_i (.clk(clk), .rst(rst), .ce(ce), .mem_wr(mem_wr),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .mem_rd_hit(mem_rd_hit),
    .instr_start(instr_start), .instr_op(instr_op), .instr_illegal(instr_illegal),
    .instr_busy(instr_busy), .instr_last(instr_last), .instr_cycles(instr_cycles),
    .mode(mode), .bank_fault(bank_fault));
  // 25 MHz clock
  always #20 clk = ~clk;
  // ==================================================
  // shared tasks
  task end_sim;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task wr(input logic [11:0] a, input logic [3:0] d);
    mem_wr = '{1'b1, a, d};
    tick;
    mem_wr.wr = 1'b0;
    tick;
  endtask
  task rd(input logic [3:0] e);
    mem_rd_addr = A;
    tick;
    chk({3'b0, mem_rd_hit}, 4'h1);
    chk(mem_rd_data, e);
  endtask
  // start one instruction, then count the cycles it stays busy
  task run(input ccms_op_e op, input logic [2:0] len, input logic ill);
    int n;
    n = 0;
    instr_op = op;
    instr_start = 1'b1;
    tick;
    instr_start = 1'b0;
    chk({1'b0, instr_cycles}, {1'b0, len});
    chk({3'b0, instr_illegal}, {3'b0, ill});
    while (instr_busy === 1'b1 && n < 9) begin
      chk({3'b0, instr_last}, {3'b0, 1'(n + 1 == int'(len))});
      n++;
      tick;
    end
    if (n > 8) begin
      num_errors++;
      end_sim;
    end
    chk(4'(n), {1'b0, len});
  endtask
  // ==================================================
  // scenarios
  task t_reset;
    rd(CCMS_STACK_SEL_RESET);
    chk({3'b0, mode.legacy}, 4'h1);
    chk({2'b0, mode.push_bytes}, 4'h2);
  endtask
  task t_legacy;
    run(CCMS_OP_CALL, 3'h3, 1'b0);
    run(CCMS_OP_FCALL, 3'h2, 1'b0);
    run(CCMS_OP_WIDE, 3'h1, 1'b1);
  endtask
  task t_ext;
    wr(A, 4'h0);
    rd(4'h0);
    run(CCMS_OP_CALL, 3'h4, 1'b0);
    chk({3'b0, mode.legacy}, 4'h0);
    chk({2'b0, mode.push_bytes}, 4'h3);
    run(CCMS_OP_FCALL, 3'h3, 1'b0);
    run(CCMS_OP_WIDE, 3'h1, 1'b0);
    run(CCMS_OP_OTHER, 3'h1, 1'b0);
  endtask
  task t_bank;
    wr(A, 4'h1);
    chk({3'b0, mode.stack_bank}, 4'h1);
    chk({3'b0, bank_fault}, 4'h0);
    wr(A, 4'h2);
    chk({3'b0, bank_fault}, 4'h1);
    wr(A, 4'h4);
    chk({3'b0, bank_fault}, 4'h1);
    chk({3'b0, mode.stack_bank}, 4'h0);
    wr(12'hf85, 4'h8);
    rd(4'h4);
    ce = 1'b0;
    wr(A, 4'h8);
    ce = 1'b1;
    rd(4'h4);
  endtask
  // a write landing with a call start is not seen by that call
  task t_switch;
    mem_wr = '{1'b1, A, 4'h8};
    instr_op = CCMS_OP_CALL;
    instr_start = 1'b1;
    tick;
    mem_wr.wr = 1'b0;
    instr_start = 1'b0;
    chk({3'b0, mode.legacy}, 4'h0);
    chk({1'b0, instr_cycles}, 4'h4);
    repeat (4) tick;
    run(CCMS_OP_CALL, 3'h3, 1'b0);
  endtask
  // ==================================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_legacy;
    t_ext;
    t_bank;
    t_switch;
    end_sim;
  end
  initial begin
    #200000;
    num_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
